// ===== design/sml_pkg.sv
// Shared constants for the system-management command link
package sml_pkg;
    // Host opcodes
    localparam logic [7:0] OP_SYNC = 8'h00;
    localparam logic [7:0] OP_SERIAL = 8'h01;
    localparam logic [7:0] OP_NETADDR = 8'h02;
    localparam logic [7:0] OP_HWVER = 8'h03;
    localparam logic [7:0] OP_FWVER = 8'h04;
    localparam logic [7:0] OP_TMAX = 8'h05;
    localparam logic [7:0] OP_TMIN = 8'h06;
    localparam logic [7:0] OP_TNOW = 8'h07;
    localparam logic [7:0] OP_VARIANT = 8'h08;
    localparam logic [7:0] OP_PWRCYC = 8'h09;
    // Reply marker bytes
    localparam logic [7:0] ACK_BYTE = 8'h06;
    localparam logic [7:0] NACK_BYTE = 8'h15;
    localparam logic [7:0] SYNC_BYTE = 8'hA5;
    // Fixed firmware version
    localparam logic [7:0] FW_MAJOR = 8'h01;
    localparam logic [7:0] FW_MINOR = 8'h00;
    // Nonvolatile memory layout: base address and byte count
    localparam logic [7:0] EE_READ_CMD = 8'h03;
    localparam logic [7:0] EE_SERIAL_BASE = 8'h00;
    localparam logic [7:0] EE_NETADDR_BASE = 8'h04;
    localparam logic [7:0] EE_HWVER_BASE = 8'h0A;
    localparam logic [7:0] EE_TMAX_BASE = 8'h0C;
    localparam logic [7:0] EE_TMIN_BASE = 8'h0D;
    localparam logic [7:0] EE_VARIANT_BASE = 8'h0E;
    localparam logic [7:0] EE_PWRCYC_BASE = 8'h12;
    localparam logic [2:0] LEN_0 = 3'h0;
    localparam logic [2:0] LEN_1 = 3'h1;
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_4 = 3'h4;
    localparam logic [2:0] LEN_6 = 3'h6;
    // Serial memory frame: 16 bits out, 8 bits in
    localparam logic [4:0] EE_LAST_OUT_BIT = 5'h0F;
    localparam logic [4:0] EE_LAST_BIT = 5'h17;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int LOOP_PERIOD_NS = 10_000_000;
    localparam int LOOP_CYCLES = LOOP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int EE_HALF_NS = 1_000;
    localparam int EE_HALF_CYCLES = EE_HALF_NS / CLK_PERIOD_NS;
    // Housekeeping periods in loop passes
    localparam logic [9:0] HK_WDOG_PASSES = 10'h064;
    localparam logic [9:0] HK_TEMP_PASSES = 10'h0C8;
    localparam logic [9:0] HK_BATT_PASSES = 10'h1F4;
    localparam logic [9:0] HK_DISP_PASSES = 10'h032;
    localparam int HK_COUNT = 4;
    // Data source of a command
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_EE = 2'b01,
        SRC_FW = 2'b10,
        SRC_TEMP = 2'b11
    } sml_src_e;
    // Command engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_EE = 2'b10,
        ST_TEMP = 2'b11
    } sml_state_e;
endpackage : sml_pkg

// ===== design/sml_stream_if.sv
// Byte stream between the command engine and the reply FIFO
`timescale 1ns/10ps
interface sml_stream_if;
    logic push_valid; // Engine offers a byte
    logic [7:0] push_data; // Byte offered
    logic push_ready; // FIFO has room
    logic flush; // Drop everything queued
    modport src (output push_valid, output push_data, output flush, input push_ready);
    modport sink (input push_valid, input push_data, input flush, output push_ready);
endinterface : sml_stream_if

// ===== design/sml_fifo.sv
// Reply FIFO, parameterised width and depth
`timescale 1ns/10ps
module sml_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Filling side
    sml_stream_if.sink in_if,
    // Draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH]; // Storage
    logic [AW-1:0] wr_q, wr_d; // Write pointer
    logic [AW-1:0] rd_q, rd_d; // Read pointer
    logic [AW:0] cnt_q, cnt_d; // Fill level
    logic do_push; // Accepted write
    logic do_pop; // Accepted read

    // Honest flags from the fill level; push_ready also drops during flush
    assign in_if.push_ready = (cnt_q != (AW+1)'(DEPTH)) && !in_if.flush;
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign do_push = in_if.push_valid && in_if.push_ready;
    assign do_pop = out_valid_o && out_ready_i;

    //////////////////////////////////////////////////////////////////
    // Pointer next state; flush wins over everything
    always_comb
    begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (in_if.flush)
        begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
        else
        begin
            if (do_push)
                wr_d = wr_q + 1'b1;
            if (do_pop)
                rd_d = rd_q + 1'b1;
            cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // Pointer registers
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage write, no reset needed for data
    always_ff @(posedge core_clk_i)
    begin
        if (do_push)
            mem_q[wr_q] <= in_if.push_data;
    end
endmodule : sml_fifo

// ===== design/sml_cmd_link.sv
// System-management command interpreter with housekeeping and merging
`timescale 1ns/10ps
module sml_cmd_link #(
    parameter int LOOP_CYCLES = sml_pkg::LOOP_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Host command write port
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic cmd_drop_o,
    // Host reply read port
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    input wire logic rsp_ready_i,
    // Serial nonvolatile memory
    output logic ee_cs_o,
    output logic ee_sck_o,
    output logic ee_dout_o,
    input wire logic ee_din_i,
    // Temperature sensor
    output logic temp_req_o,
    input wire logic temp_ack_i,
    input wire logic [7:0] temp_data_i,
    // Main loop and housekeeping
    output logic loop_pass_o,
    output logic [3:0] hk_pulse_o,
    // Keyboard (index 0) and pointer (index 1), internal and external sources
    input wire logic [1:0] int_valid_i,
    input wire logic [1:0][7:0] int_data_i,
    output logic [1:0] int_ready_o,
    input wire logic [1:0] ext_valid_i,
    input wire logic [1:0][7:0] ext_data_i,
    output logic [1:0] ext_ready_o,
    output logic [1:0] merged_valid_o,
    output logic [1:0][7:0] merged_data_o,
    // Status display
    input wire logic host_disp_valid_i,
    input wire logic [7:0] host_disp_char_i,
    output logic host_disp_ready_o,
    input wire logic ctl_disp_valid_i,
    input wire logic [7:0] ctl_disp_char_i,
    output logic disp_valid_o,
    output logic [7:0] disp_char_o
);
    //////////////////////////////////////////////////////////////////
    // Reply FIFO: decouples engine from host reads
    sml_stream_if rsp_if ();

    sml_fifo #(
        .WIDTH(8),
        .DEPTH(16)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .in_if(rsp_if.sink),
        .out_valid_o(rsp_valid_o),
        .out_data_o(rsp_data_o),
        .out_ready_i(rsp_ready_i)
    );

    //////////////////////////////////////////////////////////////////
    // Command engine state
    sml_pkg::sml_state_e state_q, state_d; // Engine state
    sml_pkg::sml_src_e src_q, src_d; // Data source of current command
    logic [7:0] byte_q, byte_d; // Byte waiting to be queued
    logic [2:0] left_q, left_d; // Data bytes still to send
    logic [7:0] addr_q, addr_d; // Next memory address
    logic [15:0] sh_q, sh_d; // Outgoing memory frame
    logic [7:0] rx_q, rx_d; // Incoming memory byte
    logic [4:0] bit_q, bit_d; // Bit index within frame
    logic cs_q, cs_d; // Memory select
    logic sck_q, sck_d; // Memory clock
    logic drop_q, drop_d; // Refused write pulse
    logic flush_c; // Abort queued reply
    logic idle_c; // Ready for a new exchange
    sml_pkg::sml_src_e dec_src; // Decoded source
    logic [7:0] dec_base; // Decoded memory base
    logic [2:0] dec_len; // Decoded byte count
    logic dec_ok; // Opcode known

    // Memory clock divider and input synchroniser
    logic [5:0] div_q, div_d; // Half-period counter
    logic ee_tick; // One enable per half period
    logic din_s1_q, din_s2_q, din_s3_q; // Three-stage synchroniser
    logic din_q, din_d; // Agreed input level

    //////////////////////////////////////////////////////////////////
    // Opcode decode; no clock-chip opcode is accepted here
    always_comb
    begin
        dec_ok = 1'b1;
        dec_src = sml_pkg::SRC_EE;
        dec_base = sml_pkg::EE_SERIAL_BASE;
        dec_len = sml_pkg::LEN_4;
        case (cmd_data_i)
            sml_pkg::OP_SERIAL: dec_base = sml_pkg::EE_SERIAL_BASE;
            sml_pkg::OP_NETADDR:
            begin
                dec_base = sml_pkg::EE_NETADDR_BASE;
                dec_len = sml_pkg::LEN_6;
            end
            sml_pkg::OP_HWVER:
            begin
                dec_base = sml_pkg::EE_HWVER_BASE;
                dec_len = sml_pkg::LEN_2;
            end
            sml_pkg::OP_FWVER:
            begin
                dec_src = sml_pkg::SRC_FW;
                dec_len = sml_pkg::LEN_2;
            end
            sml_pkg::OP_TMAX:
            begin
                dec_base = sml_pkg::EE_TMAX_BASE;
                dec_len = sml_pkg::LEN_1;
            end
            sml_pkg::OP_TMIN:
            begin
                dec_base = sml_pkg::EE_TMIN_BASE;
                dec_len = sml_pkg::LEN_1;
            end
            sml_pkg::OP_TNOW:
            begin
                dec_src = sml_pkg::SRC_TEMP;
                dec_len = sml_pkg::LEN_1;
            end
            sml_pkg::OP_VARIANT: dec_base = sml_pkg::EE_VARIANT_BASE;
            sml_pkg::OP_PWRCYC: dec_base = sml_pkg::EE_PWRCYC_BASE;
            default:
            begin
                // Unknown opcode gets a lone refusal byte
                dec_ok = 1'b0;
                dec_src = sml_pkg::SRC_NONE;
                dec_len = sml_pkg::LEN_0;
            end
        endcase
    end

    // New exchange only once engine idle and reply fully read
    assign idle_c = (state_q == sml_pkg::ST_IDLE) && !rsp_valid_o;
    assign cmd_ready_o = idle_c;
    assign cmd_drop_o = drop_q;
    assign flush_c = cmd_wr_i && (cmd_data_i == sml_pkg::OP_SYNC);
    assign rsp_if.flush = flush_c;
    assign rsp_if.push_valid = (state_q == sml_pkg::ST_PUSH);
    assign rsp_if.push_data = byte_q;
    assign temp_req_o = (state_q == sml_pkg::ST_TEMP);
    assign ee_cs_o = cs_q;
    assign ee_sck_o = sck_q;
    assign ee_dout_o = sh_q[15];

    //////////////////////////////////////////////////////////////////
    // Engine next state
    always_comb
    begin
        state_d = state_q;
        src_d = src_q;
        byte_d = byte_q;
        left_d = left_q;
        addr_d = addr_q;
        sh_d = sh_q;
        rx_d = rx_q;
        bit_d = bit_q;
        cs_d = cs_q;
        sck_d = sck_q;
        drop_d = 1'b0;
        if (flush_c)
        begin
            // Sync aborts anything in flight and answers at once
            state_d = sml_pkg::ST_PUSH;
            byte_d = sml_pkg::SYNC_BYTE;
            left_d = sml_pkg::LEN_0;
            src_d = sml_pkg::SRC_NONE;
            cs_d = 1'b0;
            sck_d = 1'b0;
        end
        else
        begin
            // Overlapping command is refused, not queued; engine runs on
            drop_d = cmd_wr_i && !idle_c;
            case (state_q)
                sml_pkg::ST_IDLE:
                begin
                    if (cmd_wr_i && idle_c)
                    begin
                        // Ack or refusal always leads the reply
                        state_d = sml_pkg::ST_PUSH;
                        byte_d = dec_ok ? sml_pkg::ACK_BYTE : sml_pkg::NACK_BYTE;
                        src_d = dec_src;
                        left_d = dec_len;
                        addr_d = dec_base;
                    end
                end
                sml_pkg::ST_PUSH:
                begin
                    if (rsp_if.push_ready)
                    begin
                        if (left_q == sml_pkg::LEN_0)
                            state_d = sml_pkg::ST_IDLE;
                        else
                        begin
                            case (src_q)
                                sml_pkg::SRC_FW:
                                begin
                                    // Major goes first, minor last
                                    byte_d = (left_q == sml_pkg::LEN_2) ?
                                        sml_pkg::FW_MAJOR : sml_pkg::FW_MINOR;
                                    left_d = left_q - 1'b1;
                                end
                                sml_pkg::SRC_TEMP: state_d = sml_pkg::ST_TEMP;
                                sml_pkg::SRC_EE:
                                begin
                                    // Start a read frame, lowest address first
                                    state_d = sml_pkg::ST_EE;
                                    sh_d = {sml_pkg::EE_READ_CMD, addr_q};
                                    bit_d = '0;
                                    cs_d = 1'b1;
                                    sck_d = 1'b0;
                                end
                                default: state_d = sml_pkg::ST_IDLE;
                            endcase
                        end
                    end
                end
                sml_pkg::ST_TEMP:
                begin
                    // Hold request until the sensor answers
                    if (temp_ack_i)
                    begin
                        byte_d = temp_data_i;
                        left_d = left_q - 1'b1;
                        state_d = sml_pkg::ST_PUSH;
                    end
                end
                sml_pkg::ST_EE:
                begin
                    if (ee_tick)
                    begin
                        if (!sck_q)
                        begin
                            // Rising edge: sample the return line
                            sck_d = 1'b1;
                            if (bit_q > sml_pkg::EE_LAST_OUT_BIT)
                                rx_d = {rx_q[6:0], din_q};
                        end
                        else
                        begin
                            // Falling edge: next command bit out
                            sck_d = 1'b0;
                            sh_d = {sh_q[14:0], 1'b0};
                            bit_d = bit_q + 1'b1;
                            if (bit_q == sml_pkg::EE_LAST_BIT)
                            begin
                                // Bytes leave in address order, msb first
                                cs_d = 1'b0;
                                byte_d = rx_q;
                                left_d = left_q - 1'b1;
                                addr_d = addr_q + 1'b1;
                                state_d = sml_pkg::ST_PUSH;
                            end
                        end
                    end
                end
                default: state_d = sml_pkg::ST_IDLE;
            endcase
        end
    end

    // Engine registers
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_q <= sml_pkg::ST_IDLE;
            src_q <= sml_pkg::SRC_NONE;
            byte_q <= 8'h00;
            left_q <= sml_pkg::LEN_0;
            addr_q <= 8'h00;
            sh_q <= 16'h0000;
            rx_q <= 8'h00;
            bit_q <= 5'h00;
            cs_q <= 1'b0;
            sck_q <= 1'b0;
            drop_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            src_q <= src_d;
            byte_q <= byte_d;
            left_q <= left_d;
            addr_q <= addr_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
            bit_q <= bit_d;
            cs_q <= cs_d;
            sck_q <= sck_d;
            drop_q <= drop_d;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Memory clock divider and return-line filter
    assign ee_tick = (div_q == 6'(sml_pkg::EE_HALF_CYCLES - 1));

    always_comb
    begin
        div_d = ee_tick ? 6'h00 : div_q + 1'b1;
        // Accept a new level only when the late stages agree
        din_d = (din_s2_q == din_s3_q) ? din_s3_q : din_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            div_q <= 6'h00;
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
            din_s3_q <= 1'b0;
            din_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            din_s1_q <= ee_din_i;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
            din_q <= din_d;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Loop pass timer and housekeeping counters
    localparam int HK_N = sml_pkg::HK_COUNT; // Number of housekeeping jobs
    logic [19:0] pass_q, pass_d; // Cycles into this pass
    logic pass_c; // Pass boundary
    logic [HK_N-1:0][9:0] hk_q, hk_d; // Passes until next job
    logic [3:0] hk_p_q, hk_p_d; // Job trigger pulses
    logic pass_p_q; // Registered pass pulse
    localparam logic [3:0][9:0] HK_RELOAD = {sml_pkg::HK_DISP_PASSES,
        sml_pkg::HK_BATT_PASSES, sml_pkg::HK_TEMP_PASSES, sml_pkg::HK_WDOG_PASSES};

    // Pass ends at most one centisecond after it began
    assign pass_c = (pass_q == 20'(LOOP_CYCLES - 1));
    assign loop_pass_o = pass_p_q;
    assign hk_pulse_o = hk_p_q;

    always_comb
    begin
        pass_d = pass_c ? 20'h00000 : pass_q + 1'b1;
        hk_d = hk_q;
        hk_p_d = 4'h0;
        for (int i = 0; i < HK_N; i++)
        begin
            // Each pass counts every job down and fires on expiry
            if (pass_c)
            begin
                if (hk_q[i] == 10'h001)
                begin
                    hk_d[i] = HK_RELOAD[i];
                    hk_p_d[i] = 1'b1;
                end
                else
                    hk_d[i] = hk_q[i] - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            pass_q <= 20'h00000;
            hk_q <= HK_RELOAD;
            hk_p_q <= 4'h0;
            pass_p_q <= 1'b0;
        end
        else
        begin
            pass_q <= pass_d;
            hk_q <= hk_d;
            hk_p_q <= hk_p_d;
            pass_p_q <= pass_c;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Input merge: alternate on contention so neither side starves
    logic [1:0] last_ext_q, last_ext_d; // Last grant went to external
    logic [1:0] mv_q, mv_d; // Merged valid
    logic [1:0][7:0] md_q, md_d; // Merged data
    logic [1:0] g_int, g_ext; // Grants this cycle

    always_comb
    begin
        last_ext_d = last_ext_q;
        md_d = md_q;
        for (int c = 0; c < 2; c++)
        begin
            g_int[c] = int_valid_i[c] && (!ext_valid_i[c] || last_ext_q[c]);
            g_ext[c] = ext_valid_i[c] && !g_int[c];
            mv_d[c] = g_int[c] || g_ext[c];
            if (g_int[c])
            begin
                md_d[c] = int_data_i[c];
                last_ext_d[c] = 1'b0;
            end
            else if (g_ext[c])
            begin
                md_d[c] = ext_data_i[c];
                last_ext_d[c] = 1'b1;
            end
        end
    end

    assign int_ready_o = g_int;
    assign ext_ready_o = g_ext;
    assign merged_valid_o = mv_q;
    assign merged_data_o = md_q;

    // Display: controller text stalls host text until it ends
    logic dv_q, dv_d; // Display strobe
    logic [7:0] dc_q, dc_d; // Display character

    always_comb
    begin
        dv_d = ctl_disp_valid_i || host_disp_valid_i;
        dc_d = ctl_disp_valid_i ? ctl_disp_char_i : host_disp_char_i;
    end

    assign host_disp_ready_o = !ctl_disp_valid_i;
    assign disp_valid_o = dv_q;
    assign disp_char_o = dc_q;

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            last_ext_q <= 2'h0;
            mv_q <= 2'h0;
            md_q <= '0;
            dv_q <= 1'b0;
            dc_q <= 8'h00;
        end
        else
        begin
            last_ext_q <= last_ext_d;
            mv_q <= mv_d;
            md_q <= md_d;
            dv_q <= dv_d;
            dc_q <= dc_d;
        end
    end
endmodule : sml_cmd_link

// ===== testbench/sml_chk.sv
// Port checker for the command link
`timescale 1ns/10ps
module sml_chk #(parameter int LOOP_CYCLES = 20) (
    input wire logic core_clk_i, reset_i, cmd_wr_i, cmd_ready_o, cmd_drop_o,
    input wire logic rsp_valid_o, temp_req_o, temp_ack_i, loop_pass_o, ee_cs_o,
    input wire logic ee_sck_o, ctl_disp_valid_i, disp_valid_o,
    input wire logic [7:0] cmd_data_i, ctl_disp_char_i, disp_char_o,
    input wire logic [1:0] int_valid_i, int_ready_o, merged_valid_o,
    input wire logic [1:0][7:0] int_data_i, merged_data_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Command taken by an idle engine
    sequence take_s;
        cmd_wr_i && cmd_ready_o;
    endsequence
    // Non-sync command while busy
    sequence refuse_s;
        cmd_wr_i && !cmd_ready_o && cmd_data_i != 8'h00;
    endsequence
    ack_lat_a: assert property (take_s |-> ##2 rsp_valid_o) else $error("no marker");
    busy_drop_a: assert property (refuse_s |=> cmd_drop_o) else $error("no drop");
    single_xchg_a: assert property (rsp_valid_o |-> !cmd_ready_o) else $error("overlap");
    loop_pass_a: assert property (loop_pass_o |-> ##LOOP_CYCLES loop_pass_o)
        else $error("pass spacing");
    temp_hold_a: assert property (temp_req_o && !temp_ack_i |=> temp_req_o)
        else $error("req dropped");
    ee_idle_a: assert property (!ee_cs_o |-> !ee_sck_o) else $error("sck idle");
    disp_prio_a: assert property (ctl_disp_valid_i |=> disp_valid_o
        && disp_char_o == $past(ctl_disp_char_i)) else $error("display");
    merge_int_a: assert property (int_valid_i[0] && int_ready_o[0] |=> merged_valid_o[0]
        && merged_data_o[0] == $past(int_data_i[0])) else $error("merge");
endmodule : sml_chk
bind sml_cmd_link sml_chk #(.LOOP_CYCLES(LOOP_CYCLES)) sml_chk_inst (.*);

// ===== testbench/sml_ee_model.sv
// Serial memory model answering byte reads
`timescale 1ns/10ps
module sml_ee_model (
    input wire logic cs_i,
    input wire logic sck_i,
    input wire logic dout_i,
    output logic din_o
);
    logic [15:0] sh = 16'h0000; // Command and address in
    logic [7:0] rd = 8'h00; // Byte going out
    int n = 0; // Rising edges this frame
    initial din_o = 1'b0;
    always @(posedge cs_i) n = 0;
    // No pull-up: released line inverts
    always @(negedge cs_i) din_o = ~din_o;
    always @(posedge sck_i)
        if (cs_i)
        begin
            sh = {sh[14:0], dout_i};
            n++;
        end
    // Data launched on falling edges
    always @(negedge sck_i)
        if (cs_i && n >= 16 && n < 24)
        begin
            if (n == 16)
                rd = (sh[15:8] == 8'h03) ? sh[7:0] ^ 8'hC3 : 8'h00;
            din_o = rd[23 - n];
        end
endmodule : sml_ee_model

// ===== testbench/sml_cmd_link_bench.sv
// Self-checking bench for the command link
`timescale 1ns/10ps
module sml_cmd_link_bench;
    logic core_clk_i = 1'b0, reset_i = 1'b1, cmd_wr_i = 1'b0, rsp_ready_i = 1'b0;
    logic temp_ack_i = 1'b0, host_disp_valid_i = 1'b0, ctl_disp_valid_i = 1'b0, ee_din_i;
    logic [7:0] cmd_data_i = 8'h00, temp_data_i = 8'h00, host_disp_char_i = 8'h00;
    logic [7:0] ctl_disp_char_i = 8'h00, rsp_data_o, disp_char_o;
    logic [1:0] int_valid_i = 2'b00, ext_valid_i = 2'b00, int_ready_o, ext_ready_o;
    logic [1:0][7:0] int_data_i = 16'h0000, ext_data_i = 16'h0000, merged_data_o;
    logic cmd_ready_o, cmd_drop_o, rsp_valid_o, ee_cs_o, ee_sck_o, ee_dout_o, temp_req_o;
    logic loop_pass_o, host_disp_ready_o, disp_valid_o;
    logic [1:0] merged_valid_o;
    logic [3:0] hk_pulse_o;
    wire [4:0] pulse_w = {hk_pulse_o, loop_pass_o}; // Loop and job pulses
    int err_count = 0, checks = 0;
    sml_cmd_link #(.LOOP_CYCLES(10)) sml_cmd_link_inst (.*);
    sml_ee_model sml_ee_model_inst (.cs_i(ee_cs_o), .sck_i(ee_sck_o), .dout_i(ee_dout_o),
        .din_o(ee_din_i));
    initial forever #10 core_clk_i = ~core_clk_i;
    task automatic check(input logic [23:0] s, input logic [23:0] e);
        checks++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask : check
    // Strobe one command byte
    task automatic send(input logic [7:0] op);
        cmd_wr_i = 1'b1;
        cmd_data_i = op;
        @(negedge core_clk_i);
        cmd_wr_i = 1'b0;
    endtask : send
    // Wait for a reply byte, judge it, pop it
    task automatic get(input logic [7:0] e);
        repeat (3000) if (rsp_valid_o !== 1'b1) @(negedge core_clk_i);
        check({rsp_valid_o, rsp_data_o}, {1'b1, e});
        rsp_ready_i = 1'b1;
        @(negedge core_clk_i);
        rsp_ready_i = 1'b0;
        @(negedge core_clk_i);
    endtask : get
    task automatic t_fw;
        send(8'h04);
        @(negedge core_clk_i);
        send(8'h07);
        check(cmd_drop_o, 1'b1);
        get(8'h06);
        get(8'h01);
        get(8'h00);
        check(cmd_ready_o, 1'b1);
    endtask : t_fw
    task automatic t_ee;
        logic [7:0] op [7] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09};
        logic [7:0] ba [7] = '{8'h00, 8'h04, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h12};
        int ln [7] = '{4, 6, 2, 1, 1, 4, 4};
        for (int i = 0; i < 7; i++)
        begin
            send(op[i]);
            get(8'h06);
            for (int j = 0; j < ln[i]; j++)
                get((ba[i] + 8'(j)) ^ 8'hC3);
        end
    endtask : t_ee
    task automatic t_temp;
        send(8'h07);
        repeat (100) if (temp_req_o !== 1'b1) @(negedge core_clk_i);
        temp_data_i = 8'h2B;
        temp_ack_i = 1'b1;
        @(negedge core_clk_i);
        temp_ack_i = 1'b0;
        get(8'h06);
        get(8'h2B);
    endtask : t_temp
    // Unknown opcode, then sync in mid-frame
    task automatic t_sync;
        send(8'h0B);
        get(8'h15);
        send(8'h01);
        repeat (300) @(negedge core_clk_i);
        send(8'h00);
        get(8'hA5);
        repeat (3000) @(negedge core_clk_i);
        check({ee_cs_o, rsp_valid_o, cmd_ready_o}, 3'b001);
    endtask : t_sync
    task automatic t_io;
        {int_valid_i, int_data_i, ext_valid_i, ext_data_i} = {2'b01, 16'h0031, 2'b10, 16'h7200};
        {ctl_disp_valid_i, ctl_disp_char_i, host_disp_valid_i, host_disp_char_i} = 18'h29B48;
        #1 check(host_disp_ready_o, 1'b0);
        @(negedge core_clk_i);
        {int_valid_i, ext_valid_i, ctl_disp_valid_i} = 5'h00;
        check({merged_valid_o, merged_data_o}, 18'h37231);
        check(disp_char_o, 8'h4D);
        @(negedge core_clk_i);
        host_disp_valid_i = 1'b0;
        check(disp_char_o, 8'h48);
    endtask : t_io
    // Spacing of one loop or housekeeping pulse
    task automatic t_per(input int b, input int e);
        int n;
        n = 1;
        repeat (6000) if (pulse_w[b] !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        repeat (6000)
            if (pulse_w[b] !== 1'b1)
            begin
                @(negedge core_clk_i);
                n++;
            end
        check(16'(n), 16'(e));
    endtask : t_per
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (20) @(negedge core_clk_i);
        reset_i = 1'b0;
        t_fw();
        t_ee();
        t_temp();
        t_sync();
        t_io();
        t_per(0, 10);
        t_per(4, 500);
        t_per(1, 1000);
        t_per(2, 2000);
        t_per(3, 5000);
        tally_and_finish();
    end
    // Hang guard, well past the expected run
    initial
    begin
        #1_900_000;
        err_count++;
        tally_and_finish();
    end
endmodule : sml_cmd_link_bench
